// ==== tpasb_pkg.sv ====
// tpasb_pkg: constants, register map and types for the auxiliary scan and sample buffer block
package tpasb_pkg;

    // ********
    // register indexes (byte address is four times the index)
    // ********
    localparam logic [31:0] IDX_AUX_CTRL   = 32'h0b000130;
    localparam logic [31:0] IDX_AUX_MASK   = 32'h0b000132;
    localparam logic [31:0] IDX_INTV_READ  = 32'h0b00013e;
    localparam int          NUM_BUF        = 14;
    // entries 0..4 page 0 (x+, x-, y+, y-, pressure), 5..9 page 1, 10..13 aux channels
    localparam logic [31:0] IDX_BUF [NUM_BUF] = '{
        32'h0b0002a0, 32'h0b0002a2, 32'h0b0002a4, 32'h0b0002a6, 32'h0b0002bc,
        32'h0b0002a8, 32'h0b0002aa, 32'h0b0002ac, 32'h0b0002ae, 32'h0b0002be,
        32'h0b0002b0, 32'h0b0002b2, 32'h0b0002b4, 32'h0b0002b6};
    localparam int          PAGE_ENTRIES   = 5;
    localparam int          AUX_BASE       = 10;

    // ********
    // field positions and reset values
    // ********
    localparam int          GO_BIT         = 0;
    localparam int          PPSEL_BIT      = 1;
    localparam int          VALID_BIT      = 15;
    localparam int          MASK_W         = 8;
    localparam int          INTV_W         = 11;
    localparam int          SETTLE_W       = 6;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    // ********
    // timing
    // ********
    localparam int          UNIT_US        = 30;
    localparam int          CLK_MHZ        = 50;
    localparam int          UNIT_CYCLES    = UNIT_US * CLK_MHZ;
    localparam int          UNIT_CNT_W     = $clog2(UNIT_CYCLES);

    // ********
    // types
    // ********
    typedef enum logic [6:0] {
        SEQ_DISABLE      = 7'h01,
        SEQ_STANDBY      = 7'h02,
        SEQ_AWAIT_TOUCH  = 7'h04,
        SEQ_COORD_SCAN   = 7'h08,
        SEQ_INTERVAL     = 7'h10,
        SEQ_CMD_SCAN     = 7'h20,
        SEQ_AUX_SCAN     = 7'h40
    } tpasb_seq_type;

    typedef enum logic [2:0] {
        AUX_IDLE  = 3'h1,
        AUX_ISSUE = 3'h2,
        AUX_WAIT  = 3'h4
    } tpasb_aux_type;

    typedef struct packed {
        logic       valid;
        logic [9:0] value;
    } tpasb_sample_type;

    typedef struct packed {
        logic       start;
        logic [2:0] channel;
    } tpasb_adc_req_type;

endpackage : tpasb_pkg

// ==== tpasb_top.sv ====
// tpasb_top: auxiliary scan control, interval readback and two-page sample buffers on APB
// Operation
// - writing one to aux_scan_go in standby, touch wait or interval wait starts an auxiliary scan of selected channels
// - after a completed or timed-out auxiliary scan the sequencer returns to the state it left
// - hardware clears aux_scan_go when the auxiliary scan completes
// - scan exceeding the settling time raises sample_lost_event as timeout
// - panel_pin_select one picks panel pins, zero picks general analog pins
// - panel_pin_select changes are stored without any sequencer state change
// - reserved bits read as zero in every register
// - a set channel mask bit skips conversion of that channel; bit 7 is sound
// - channel masks only act during the auxiliary scan
// - interval readback shows the live 11-bit countdown of the scan interval
// - each buffer holds a 10-bit result low and a valid flag in bit 15
// - four coordinate and one pressure buffer, each on two pages, fixed addresses
// - clearing a page-full cause clears that page's valid flags
// - settling field counts 30 us units and also sets the auxiliary timeout
// - page entries x+, x-, y+, y-, pressure; four fixed aux channel buffers
module tpasb_top #(
    parameter int DATA_W = 10
) (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // rest of the scan sequencer
    input  wire tpasb_pkg::tpasb_seq_type      main_state,
    input  wire logic [tpasb_pkg::SETTLE_W-1:0] settle_time,
    input  wire logic [tpasb_pkg::INTV_W-1:0]  scan_interval_setting,
    input  wire logic                          coord_wr,
    input  wire logic                          coord_page,
    input  wire logic [2:0]                    coord_index,
    input  wire logic [DATA_W-1:0]             coord_value,
    input  wire logic                          first_page_full_cause_clr,
    input  wire logic                          second_page_full_cause_clr,
    input  wire logic                          aux_cause_clr,
    output tpasb_pkg::tpasb_seq_type           seq_state,
    output logic                               sample_lost_event,
    // a/d converter
    output tpasb_pkg::tpasb_adc_req_type       adc_req,
    input  wire logic                          adc_done,
    input  wire logic [DATA_W-1:0]             adc_value
);

    // ********
    // elaboration check
    // ********
    if (DATA_W < 1 || DATA_W > 10)
    begin : g_bad_width
        $error("tpasb_top: DATA_W must lie between 1 and 10");
    end

    // ********
    // declarations
    // ********
    tpasb_pkg::tpasb_seq_type                seq_state_reg;
    tpasb_pkg::tpasb_seq_type                return_state_reg;
    tpasb_pkg::tpasb_aux_type                aux_state_reg;
    tpasb_pkg::tpasb_adc_req_type            adc_req_reg;
    tpasb_pkg::tpasb_sample_type             buf_reg [tpasb_pkg::NUM_BUF];
    logic                                    aux_go_reg;
    logic                                    ppsel_reg;
    logic [tpasb_pkg::MASK_W-1:0]            mask_reg;
    logic [1:0]                              chan_reg;
    logic [tpasb_pkg::UNIT_CNT_W-1:0]        unit_cnt_reg;
    logic [tpasb_pkg::SETTLE_W-1:0]          timeout_cnt_reg;
    logic [tpasb_pkg::INTV_W-1:0]            intv_cnt_reg;
    logic                                    lost_reg;
    logic [31:0]                             prdata_reg;
    logic                                    pready_reg;
    logic                                    pslverr_reg;
    logic [31:0]                             prdata_next;
    logic                                    hit_next;
    logic                                    wr_access;
    logic                                    unit_tick;
    logic                                    aux_start;
    logic                                    aux_abort;
    logic                                    aux_finish;
    logic                                    aux_timeout;
    logic                                    aux_store;
    logic [2:0]                              aux_code;

    // ********
    // apb slave
    // ********
    // one wait state: data and error are registered in the first access cycle
    assign wr_access = psel & penable & pready_reg & pwrite;

    // read mux and address decode
    always_comb
    begin
        prdata_next = 32'h00000000;
        hit_next    = 1'b0;
        if (paddr == {tpasb_pkg::IDX_AUX_CTRL[29:0], 2'b00})
        begin
            hit_next                          = 1'b1;
            prdata_next[tpasb_pkg::GO_BIT]    = aux_go_reg;
            prdata_next[tpasb_pkg::PPSEL_BIT] = ppsel_reg;
        end
        else if (paddr == {tpasb_pkg::IDX_AUX_MASK[29:0], 2'b00})
        begin
            hit_next                            = 1'b1;
            prdata_next[tpasb_pkg::MASK_W-1:0]  = mask_reg;
        end
        else if (paddr == {tpasb_pkg::IDX_INTV_READ[29:0], 2'b00})
        begin
            hit_next                            = 1'b1;
            prdata_next[tpasb_pkg::INTV_W-1:0]  = intv_cnt_reg;
        end
        for (int i = 0; i < tpasb_pkg::NUM_BUF; i++)
        begin
            if (paddr == {tpasb_pkg::IDX_BUF[i][29:0], 2'b00})
            begin
                hit_next                            = 1'b1;
                // value low, valid in bit 15
                prdata_next[tpasb_pkg::VALID_BIT]   = buf_reg[i].valid;
                prdata_next[DATA_W-1:0]             = buf_reg[i].value[DATA_W-1:0];
            end
        end
    end

    // handshake and registered answer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= psel & penable & ~pready_reg;
            prdata_reg  <= (psel & penable & ~pready_reg & ~pwrite) ? prdata_next : 32'h00000000;
            pslverr_reg <= psel & penable & ~pready_reg & ~hit_next;
        end
    end

    // ********
    // control registers
    // ********
    // go bit: software sets, hardware clears on completion; the clear by hardware
    // wins against any same-cycle write; a write of one then cannot start a new scan anyway
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aux_go_reg <= 1'b0;
            ppsel_reg  <= 1'b0;
            mask_reg   <= tpasb_pkg::REG_RESET[tpasb_pkg::MASK_W-1:0];
        end
        else
        begin
            if (wr_access && paddr == {tpasb_pkg::IDX_AUX_CTRL[29:0], 2'b00})
            begin
                // value kept, no state change here
                ppsel_reg  <= pwdata[tpasb_pkg::PPSEL_BIT];
                aux_go_reg <= pwdata[tpasb_pkg::GO_BIT] & (aux_go_reg | aux_start);
            end
            if (wr_access && paddr == {tpasb_pkg::IDX_AUX_MASK[29:0], 2'b00})
            begin
                mask_reg <= pwdata[tpasb_pkg::MASK_W-1:0];
            end
            if (aux_finish)
            begin
                aux_go_reg <= 1'b0;
            end
        end
    end

    // a start is honoured only from standby, touch wait or interval wait
    // other states ignore the write, leaving the bit low
    assign aux_start = wr_access && paddr == {tpasb_pkg::IDX_AUX_CTRL[29:0], 2'b00}
                       && pwdata[tpasb_pkg::GO_BIT] && !aux_go_reg
                       && (seq_state_reg == tpasb_pkg::SEQ_STANDBY
                           || seq_state_reg == tpasb_pkg::SEQ_AWAIT_TOUCH
                           || seq_state_reg == tpasb_pkg::SEQ_INTERVAL);
    // writing zero to go during the scan abandons it and powers down
    assign aux_abort = wr_access && paddr == {tpasb_pkg::IDX_AUX_CTRL[29:0], 2'b00}
                       && !pwdata[tpasb_pkg::GO_BIT] && aux_state_reg != tpasb_pkg::AUX_IDLE;

    // ********
    // 30 us time base
    // ********
    // free running so that countdown and timeout share one unit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            unit_cnt_reg <= '0;
        end
        else if (unit_tick)
        begin
            unit_cnt_reg <= '0;
        end
        else
        begin
            unit_cnt_reg <= unit_cnt_reg + 1'b1;
        end
    end
    assign unit_tick = (unit_cnt_reg == tpasb_pkg::UNIT_CNT_W'(tpasb_pkg::UNIT_CYCLES - 1));

    // ********
    // interval countdown
    // ********
    // counts down from the interval setting while waiting, reloads at zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            intv_cnt_reg <= '0;
        end
        else if (seq_state_reg != tpasb_pkg::SEQ_INTERVAL)
        begin
            intv_cnt_reg <= scan_interval_setting;
        end
        else if (unit_tick)
        begin
            intv_cnt_reg <= (intv_cnt_reg == '0) ? scan_interval_setting : intv_cnt_reg - 1'b1;
        end
    end

    // ********
    // sequencer state and auxiliary scan
    // ********
    // timeout in 30 us units; the partial unit at start makes it up to one unit late
    assign aux_timeout = aux_state_reg != tpasb_pkg::AUX_IDLE && unit_tick
                         && timeout_cnt_reg >= settle_time;
    // code high bit clear selects panel pins, set selects general pins
    assign aux_code    = {~ppsel_reg, chan_reg};
    assign aux_store   = aux_state_reg == tpasb_pkg::AUX_WAIT && adc_done;
    // masks are consulted only inside the auxiliary scan, here and in the channel walk
    assign aux_finish  = aux_timeout || aux_abort
                         || (chan_reg == 2'h3 && (aux_store
                             || (aux_state_reg == tpasb_pkg::AUX_ISSUE && mask_reg[aux_code])));

    // channel walk: skip masked channels, convert the rest in order
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aux_state_reg   <= tpasb_pkg::AUX_IDLE;
            chan_reg        <= 2'h0;
            adc_req_reg     <= '0;
            timeout_cnt_reg <= '0;
            lost_reg        <= 1'b0;
        end
        else
        begin
            lost_reg          <= aux_timeout;
            adc_req_reg.start <= 1'b0;
            if (unit_tick)
            begin
                timeout_cnt_reg <= timeout_cnt_reg + 1'b1;
            end
            if (aux_finish)
            begin
                aux_state_reg <= tpasb_pkg::AUX_IDLE;
            end
            else
            begin
                case (aux_state_reg)
                    tpasb_pkg::AUX_IDLE:
                    begin
                        chan_reg        <= 2'h0;
                        timeout_cnt_reg <= '0;
                        if (aux_start)
                        begin
                            aux_state_reg <= tpasb_pkg::AUX_ISSUE;
                        end
                    end
                    tpasb_pkg::AUX_ISSUE:
                    begin
                        if (mask_reg[aux_code])
                        begin
                            chan_reg <= chan_reg + 2'h1;
                        end
                        else
                        begin
                            adc_req_reg.start   <= 1'b1;
                            adc_req_reg.channel <= aux_code;
                            aux_state_reg       <= tpasb_pkg::AUX_WAIT;
                        end
                    end
                    tpasb_pkg::AUX_WAIT:
                    begin
                        if (adc_done)
                        begin
                            chan_reg      <= chan_reg + 2'h1;
                            aux_state_reg <= tpasb_pkg::AUX_ISSUE;
                        end
                    end
                    default:
                    begin
                        aux_state_reg <= tpasb_pkg::AUX_IDLE;
                    end
                endcase
            end
        end
    end

    // effective sequencer state: follows the main sequencer outside the scan
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            seq_state_reg    <= tpasb_pkg::SEQ_DISABLE;
            return_state_reg <= tpasb_pkg::SEQ_DISABLE;
        end
        else if (aux_start)
        begin
            return_state_reg <= seq_state_reg;
            seq_state_reg    <= tpasb_pkg::SEQ_AUX_SCAN;
        end
        else if (aux_abort)
        begin
            seq_state_reg <= tpasb_pkg::SEQ_DISABLE;
        end
        else if (aux_finish)
        begin
            seq_state_reg <= return_state_reg;
        end
        else if (aux_state_reg == tpasb_pkg::AUX_IDLE)
        begin
            seq_state_reg <= main_state;
        end
    end

    // ********
    // sample buffers
    // ********
    // one generate entry per buffer; hardware store wins over clears
    for (genvar g = 0; g < tpasb_pkg::NUM_BUF; g++)
    begin : g_buf
        logic hw_wr;
        logic cause_clr;
        if (g < tpasb_pkg::AUX_BASE)
        begin : g_page
            assign hw_wr = coord_wr
                           && coord_page == (g >= tpasb_pkg::PAGE_ENTRIES)
                           && coord_index == 3'(g % tpasb_pkg::PAGE_ENTRIES);
            // page cause clear drops that page's valid flags
            assign cause_clr = (g < tpasb_pkg::PAGE_ENTRIES) ? first_page_full_cause_clr
                                                             : second_page_full_cause_clr;
        end
        else
        begin : g_aux
            assign hw_wr     = aux_store && chan_reg == 2'(g - tpasb_pkg::AUX_BASE);
            assign cause_clr = aux_cause_clr;
        end

        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                buf_reg[g] <= '0;
            end
            else if (hw_wr)
            begin
                buf_reg[g].value <= 10'(g < tpasb_pkg::AUX_BASE ? coord_value : adc_value);
                buf_reg[g].valid <= 1'b1;
            end
            else if (wr_access && paddr == {tpasb_pkg::IDX_BUF[g][29:0], 2'b00})
            begin
                buf_reg[g].value <= 10'(pwdata[DATA_W-1:0]);
                buf_reg[g].valid <= pwdata[tpasb_pkg::VALID_BIT] & ~cause_clr;
            end
            else if (cause_clr)
            begin
                buf_reg[g].valid <= 1'b0;
            end
        end
    end

    // ********
    // outputs
    // ********
    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign seq_state         = seq_state_reg;
    assign sample_lost_event = lost_reg;
    assign adc_req           = adc_req_reg;

endmodule : tpasb_top

// ==== tpasb_adc_model.sv ====
// tpasb_adc_model: converter that answers each request a few cycles later
module tpasb_adc_model (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire tpasb_pkg::tpasb_adc_req_type adc_req,
    input  wire logic                         stall,
    output logic                              adc_done,
    output logic [9:0]                        adc_value
);
    logic [2:0] wait_reg;
    logic [2:0] chan_reg;
    // ********
    // conversion
    // ********
    // result tied to channel; stall never answers so the timeout fires
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_reg  <= 3'h0;
            chan_reg  <= 3'h0;
            adc_done  <= 1'b0;
            adc_value <= 10'h000;
        end
        else
        begin
            adc_done  <= 1'b0;
            adc_value <= ~adc_value; // no stale value between answers
            if (adc_req.start)
            begin
                wait_reg <= 3'h4;
                chan_reg <= adc_req.channel;
            end
            else if (wait_reg != 3'h0 && !stall)
                wait_reg <= wait_reg - 3'h1;
            if (wait_reg == 3'h1 && !stall)
            begin
                adc_done  <= 1'b1;
                adc_value <= {7'h54, chan_reg};
            end
        end
    end
endmodule : tpasb_adc_model

// ==== tpasb_assertions.sv ====
// tpasb_assertions: port checker for tpasb_top
module tpasb_chk (
    input wire logic                         clk,
    input wire logic                         reset_n,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire tpasb_pkg::tpasb_seq_type     main_state,
    input wire tpasb_pkg::tpasb_seq_type     seq_state,
    input wire logic                         sample_lost_event,
    input wire tpasb_pkg::tpasb_adc_req_type adc_req
);
    // ********
    // checks
    // ********
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_ready_time: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not idle");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper bits set");
    a_start_aux: assert property (adc_req.start |-> seq_state == tpasb_pkg::SEQ_AUX_SCAN)
        else $error("request outside scan");
    a_lost_pulse: assert property (sample_lost_event |=> !sample_lost_event)
        else $error("lost held");
    a_lost_aux: assert property (sample_lost_event |-> seq_state == tpasb_pkg::SEQ_AUX_SCAN
        || $past(seq_state) == tpasb_pkg::SEQ_AUX_SCAN)
        else $error("lost outside scan");
    a_state_follow: assert property ($past(reset_n, 2) && $past(reset_n)
        && seq_state != tpasb_pkg::SEQ_AUX_SCAN && $past(seq_state) != tpasb_pkg::SEQ_AUX_SCAN
        |-> seq_state == $past(main_state)) else $error("state not followed");
endmodule : tpasb_chk

bind tpasb_top tpasb_chk u_chk (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_state(main_state),
    .seq_state(seq_state), .sample_lost_event(sample_lost_event), .adc_req(adc_req));

// ==== touch_panel_aux_scan_buffers_bench.sv ====
// touch_panel_aux_scan_buffers_bench: self-checking bench for tpasb_top
module touch_panel_aux_scan_buffers_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic er, coord_wr = 1'b0, coord_page = 1'b0, clr0 = 1'b0, clr1 = 1'b0, aux_clr = 1'b0;
    logic stall = 1'b0, adc_done;
    logic [2:0] coord_index = 3'h0;
    logic [9:0] coord_value = 10'h0, adc_value;
    logic [5:0] settle_time = 6'h3f; // long enough that normal scans never time out
    logic [10:0] intv = 11'h123;
    tpasb_pkg::tpasb_seq_type main_state = tpasb_pkg::SEQ_STANDBY, seq_state;
    tpasb_pkg::tpasb_adc_req_type adc_req;
    logic lost;
    logic [2:0] chq[$];
    logic [15:0] aux_exp[4] = '{default: 16'h0};
    int num_errors = 0, check_count = 0;

    tpasb_top u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_state(main_state), .settle_time(settle_time), .scan_interval_setting(intv),
        .coord_wr(coord_wr), .coord_page(coord_page), .coord_index(coord_index),
        .coord_value(coord_value), .first_page_full_cause_clr(clr0),
        .second_page_full_cause_clr(clr1), .aux_cause_clr(aux_clr), .seq_state(seq_state),
        .sample_lost_event(lost), .adc_req(adc_req), .adc_done(adc_done), .adc_value(adc_value));
    tpasb_adc_model u_adc (.clk(clk), .reset_n(reset_n), .adc_req(adc_req), .stall(stall),
        .adc_done(adc_done), .adc_value(adc_value));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // record the channel order the converter is asked for
    always @(posedge clk)
        if (adc_req.start === 1'b1)
            chq.push_back(adc_req.channel);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one apb transfer; starts after an edge so back-to-back calls never collide
    task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= idx << 2;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("apb answer", n < 20, 1);
    endtask : apb
    task automatic rdc(input string what, input logic [31:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(what, rd, exp);
    endtask : rdc
    task automatic pulse(input int which);
        @(posedge clk);
        {aux_clr, clr1, clr0} <= 3'h1 << which;
        @(posedge clk);
        {aux_clr, clr1, clr0} <= 3'h0;
    endtask : pulse

    task automatic t_reset_regs;
        rdc("ctrl", tpasb_pkg::IDX_AUX_CTRL, 0);
        for (int i = 0; i < tpasb_pkg::NUM_BUF; i++)
            rdc("buffer", tpasb_pkg::IDX_BUF[i], 0);
        rdc("unmapped", 32'h0, 0);
        check("slverr", er, 1);
        apb(1'b1, tpasb_pkg::IDX_AUX_MASK, 32'hffffffff);
        rdc("mask", tpasb_pkg::IDX_AUX_MASK, 32'hff);
        apb(1'b1, tpasb_pkg::IDX_AUX_CTRL, 32'hfffffffe);
        rdc("ctrl", tpasb_pkg::IDX_AUX_CTRL, 32'h2);
        check("state kept", seq_state, tpasb_pkg::SEQ_STANDBY);
    endtask : t_reset_regs

    task automatic t_aux(input tpasb_pkg::tpasb_seq_type st, input logic sel, input logic [7:0] mask);
        int b, n;
        logic [2:0] ex[$];
        b = sel ? 0 : 4;
        main_state <= st;
        pulse(2);
        for (int i = 0; i < 4; i++)
            aux_exp[i] &= 16'h03ff;
        chq.delete();
        apb(1'b1, tpasb_pkg::IDX_AUX_MASK, {24'h0, mask});
        apb(1'b1, tpasb_pkg::IDX_AUX_CTRL, {30'h0, sel, 1'b1});
        @(posedge clk);
        check("scan state", seq_state, tpasb_pkg::SEQ_AUX_SCAN);
        n = 0;
        while (seq_state === tpasb_pkg::SEQ_AUX_SCAN && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        check("state back", seq_state, st);
        rdc("go cleared", tpasb_pkg::IDX_AUX_CTRL, {30'h0, sel, 1'b0});
        for (int i = 0; i < 4; i++)
            if (!mask[b + i])
            begin
                ex.push_back(3'(b + i));
                aux_exp[i] = 16'h8000 | (16'h2a0 + 16'(b + i));
            end
        check("channels", chq.size(), ex.size());
        foreach (ex[i])
            check("channel", chq[i], ex[i]);
        for (int i = 0; i < 4; i++)
            rdc("aux buffer", tpasb_pkg::IDX_BUF[tpasb_pkg::AUX_BASE + i], aux_exp[i]);
    endtask : t_aux

    task automatic t_coord;
        for (int k = 0; k < 10; k++)
        begin
            @(posedge clk);
            coord_wr <= 1'b1;
            coord_page <= k >= 5;
            coord_index <= 3'(k % 5);
            coord_value <= 10'(9'h100 + k);
            @(posedge clk);
            coord_wr <= 1'b0;
        end
        for (int c = -1; c < 2; c++)
        begin
            if (c >= 0)
                pulse(c);
            for (int k = 0; k < 10; k++)
                rdc("page buffer", tpasb_pkg::IDX_BUF[k], {(k / 5) > c, 6'h0, 9'h100 + 9'(k)});
        end
    endtask : t_coord

    task automatic t_timeout;
        int n;
        stall <= 1'b1;
        settle_time <= 6'h1;
        apb(1'b1, tpasb_pkg::IDX_AUX_CTRL, 32'h1);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (lost !== 1'b1 && n < 3200);
        check("timeout event", lost, 1);
        rdc("go cleared", tpasb_pkg::IDX_AUX_CTRL, 0);
        check("state back", seq_state, tpasb_pkg::SEQ_STANDBY);
        stall <= 1'b0;
    endtask : t_timeout

    task automatic t_countdown;
        rdc("countdown", tpasb_pkg::IDX_INTV_READ, intv);
        main_state <= tpasb_pkg::SEQ_INTERVAL;
        repeat (1600) @(posedge clk);
        apb(1'b0, tpasb_pkg::IDX_INTV_READ, 32'h0);
        check("countdown moving", rd < intv && rd + 2 >= intv, 1);
    endtask : t_countdown

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_regs();
        // go raised only from allowed states
        t_aux(tpasb_pkg::SEQ_STANDBY, 1'b1, 8'h02);
        t_aux(tpasb_pkg::SEQ_AWAIT_TOUCH, 1'b0, 8'h80);
        t_aux(tpasb_pkg::SEQ_STANDBY, 1'b0, 8'h0f);
        t_coord();
        t_timeout();
        t_countdown();
        final_report();
    end
endmodule : touch_panel_aux_scan_buffers_bench
